// *** design/psc_top.sv ***
// psc_top: low-power state control and peripheral bus clock scaling
// assumes the core, interrupt controller and watchdog share core_system_clock
`timescale 1ns/1ps
// Operation
// RQ1 - leave sleep on enabled sleep-capable interrupt above core priority
// RQ2 - low-priority wake from sleep restarts peripheral clock and enters idle
// RQ3 - any reset or watchdog time-out exits sleep
// RQ4 - idle halts core while system clock keeps running
// RQ5 - peripherals with stop-in-idle bit set halt in idle
// RQ6 - wait with sleep-select clear enters idle
// RQ7 - wait with sleep-select set enters sleep, stopping both clocks
// RQ8 - idle exits on interrupt above core priority, else stays idle
// RQ9 - any reset or watchdog time-out exits idle
// RQ10 - two-bit divisor sets peripheral bus clock ratio 1:1 to 1:8
// RQ11 - divisor codes 00,01,10,11 give 1:1,1:2,1:4,1:8
// RQ12 - system-clock units ignore the peripheral divisor
// RQ13 - peripheral read completes at next peripheral bus clock edge
// RQ14 - switch to disabled crystal or pll source waits start-up and lock
// RQ15 - leaving idle adds no oscillator start-up delay
module psc_top
  import psc_pkg::*;
#(
  parameter int NPERIPH   = psc_pkg::PSC_NPERIPH,
  parameter int OSC_DELAY = psc_pkg::PSC_OSC_START_CYC,
  parameter int PLL_DELAY = psc_pkg::PSC_PLL_LOCK_CYC
)
(
  // clock and reset
  input  wire logic                        clock,
  input  wire logic                        reset,
  // core events
  input  wire logic                        wait_exec,
  input  wire logic                        sleep_select_bit,
  input  wire logic [psc_pkg::PSC_DIV_W-1:0] periph_clock_divisor,
  input  wire logic [psc_pkg::PSC_PRIO_W-1:0] cpu_priority,
  // wake sources
  input  wire logic                        irq_valid,
  input  wire logic                        irq_runs_in_sleep,
  input  wire logic [psc_pkg::PSC_PRIO_W-1:0] irq_priority,
  input  wire logic                        wdt_timeout,
  // peripherals
  input  wire logic [NPERIPH-1:0]          stop_in_idle_bit,
  input  wire logic                        periph_read_req,
  // clock source switch
  input  wire logic                        src_switch_req,
  input  wire logic                        src_was_disabled,
  input  wire logic                        src_uses_xtal,
  input  wire logic                        src_uses_pll,
  // outputs
  output logic                             core_halted,
  output logic                             core_system_clock_run,
  output logic                             sys_unit_clk_en,
  output logic                             peripheral_bus_clock,
  output logic [NPERIPH-1:0]               periph_clk_en,
  output logic                             periph_read_done,
  output logic                             src_ready,
  output psc_pkg::psc_mode_t               mode
);
  import psc_pkg::*;

  psc_mode_t            next_mode;
  logic                 pb_edge;
  logic [PSC_CNT_W-1:0] div_count;
  logic                 div_run;
  logic                 next_core_halted;
  logic                 next_core_system_clock_run;
  logic                 next_peripheral_bus_clock;
  logic [NPERIPH-1:0]   next_periph_clk_en;
  logic                 rd_pend;
  logic                 next_rd_pend;
  logic                 next_rd_done;
  logic [PSC_DLY_W-1:0] dly;
  logic [PSC_DLY_W-1:0] next_dly;
  logic                 next_src_ready;
  logic                 hi_irq;

  // peripheral clock stops only in sleep
  assign div_run = (mode != PSC_SLEEP); // RQ7

  psc_clkdiv psc_clkdiv_i (
    .clock                (clock),
    .reset                (reset),
    .run                  (div_run),
    .periph_clock_divisor (periph_clock_divisor), // RQ10 RQ11
    .pb_edge              (pb_edge),
    .count                (div_count)
  );

  // mode state
  always_comb begin
    hi_irq    = irq_valid && (irq_priority > cpu_priority);
    next_mode = mode;
    case (mode)
      PSC_RUN: begin
        if (wait_exec)
          next_mode = sleep_select_bit ? PSC_SLEEP : PSC_IDLE; // RQ6 RQ7
      end
      PSC_IDLE: begin
        // no start-up wait on exit: the source never stopped
        if (hi_irq || wdt_timeout)
          next_mode = PSC_RUN; // RQ8 RQ9 RQ15
      end
      PSC_SLEEP: begin
        if (wdt_timeout || (hi_irq && irq_runs_in_sleep))
          next_mode = PSC_RUN; // RQ1 RQ3
        else if (irq_valid && irq_runs_in_sleep)
          next_mode = PSC_IDLE; // RQ2
      end
      default: next_mode = PSC_RUN;
    endcase
    next_core_halted   = (next_mode != PSC_RUN); // RQ4
    next_core_system_clock_run    = (next_mode != PSC_SLEEP); // RQ4 RQ7
    next_periph_clk_en = '1;
    if (next_mode == PSC_SLEEP)
      next_periph_clk_en = '0;
    else if (next_mode == PSC_IDLE)
      next_periph_clk_en = ~stop_in_idle_bit; // RQ5
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      // reset of any kind lands in run
      mode          <= PSC_RUN; // RQ3 RQ9
      core_halted   <= 1'b0;
      core_system_clock_run    <= 1'b1;
      periph_clk_en <= '1;
    end else begin
      mode          <= next_mode;
      core_halted   <= next_core_halted;
      core_system_clock_run    <= next_core_system_clock_run;
      periph_clk_en <= next_periph_clk_en;
    end
  end

  // peripheral clock level and read completion
  always_comb begin
    next_peripheral_bus_clock   = peripheral_bus_clock;
    // high for the first half of each period; the wrap to zero always carries pb_edge,
    // so the fall must come from the upper counts. at 1:1 the level stays high
    if (pb_edge)
      next_peripheral_bus_clock = 1'b1;
    else if (div_count > (psc_div_last(periph_clock_divisor) >> 1))
      next_peripheral_bus_clock = 1'b0; // RQ10
    next_rd_pend = rd_pend | periph_read_req;
    next_rd_done = 1'b0;
    if (next_rd_pend && pb_edge) begin
      next_rd_done = 1'b1; // RQ13
      next_rd_pend = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      peripheral_bus_clock <= 1'b0;
      rd_pend              <= 1'b0;
      periph_read_done     <= 1'b0;
      sys_unit_clk_en      <= 1'b1;
    end else begin
      peripheral_bus_clock <= next_peripheral_bus_clock;
      rd_pend              <= next_rd_pend;
      periph_read_done     <= next_rd_done;
      // system-clock units follow sleep only, never the divisor
      sys_unit_clk_en      <= next_core_system_clock_run; // RQ12
    end
  end

  // clock source start-up and lock wait
  always_comb begin
    next_dly       = dly;
    next_src_ready = src_ready;
    if (src_switch_req) begin
      if (src_was_disabled && (src_uses_xtal || src_uses_pll)) begin
        next_dly = PSC_DLY_W'((src_uses_xtal ? OSC_DELAY : 0)
                            + (src_uses_pll ? PLL_DELAY : 0)); // RQ14
        next_src_ready = 1'b0;
      end else begin
        next_dly       = '0;
        next_src_ready = 1'b1;
      end
    end else if (dly != '0) begin
      next_dly = dly - 1'b1;
      if (dly == PSC_DLY_W'(1))
        next_src_ready = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      dly       <= '0;
      src_ready <= 1'b1;
    end else begin
      dly       <= next_dly;
      src_ready <= next_src_ready;
    end
  end

  chk_wait_idle: assert property (@(posedge clock) disable iff (reset) // RQ6
    (mode == PSC_RUN && wait_exec && !sleep_select_bit) |=> mode == PSC_IDLE)
    else $error("wait did not enter idle");
  chk_wait_sleep: assert property (@(posedge clock) disable iff (reset) // RQ7
    (mode == PSC_RUN && wait_exec && sleep_select_bit) |=> mode == PSC_SLEEP
    && !core_system_clock_run && periph_clk_en == '0)
    else $error("wait did not enter sleep");
  chk_sleep_wake: assert property (@(posedge clock) disable iff (reset) // RQ1
    (mode == PSC_SLEEP && irq_valid && irq_runs_in_sleep
     && irq_priority > cpu_priority) |=> mode == PSC_RUN && !core_halted)
    else $error("sleep missed wake");
  chk_sleep_low: assert property (@(posedge clock) disable iff (reset) // RQ2
    (mode == PSC_SLEEP && !wdt_timeout && irq_valid && irq_runs_in_sleep
     && irq_priority <= cpu_priority) |=> mode == PSC_IDLE && core_halted)
    else $error("low wake not idle");
  chk_wdt_exit: assert property (@(posedge clock) disable iff (reset) // RQ3 RQ9
    (mode != PSC_RUN && wdt_timeout) |=> mode == PSC_RUN)
    else $error("watchdog did not wake");
  chk_idle_stay: assert property (@(posedge clock) disable iff (reset) // RQ8
    (mode == PSC_IDLE && !wdt_timeout && !(irq_valid && irq_priority > cpu_priority))
    |=> mode == PSC_IDLE)
    else $error("idle left without cause");
  chk_idle_gate: assert property (@(posedge clock) disable iff (reset) // RQ4 RQ5
    (mode == PSC_IDLE) |-> core_system_clock_run && periph_clk_en == ~$past(stop_in_idle_bit))
    else $error("idle gating wrong");
  chk_read_edge: assert property (@(posedge clock) disable iff (reset) // RQ13
    (periph_read_req && !rd_pend && periph_clock_divisor == PSC_DIV8 && mode != PSC_SLEEP)
    |-> ##[1:9] periph_read_done)
    else $error("read did not complete");
  chk_src_wait: assert property (@(posedge clock) disable iff (reset) // RQ14
    (src_switch_req && src_was_disabled && src_uses_xtal) |=> !src_ready)
    else $error("start-up delay skipped");
endmodule : psc_top

// *** design/psc_pkg.sv ***
// psc_pkg: constants and types shared by the power-save and peripheral clock block
// assumes a single core_system_clock domain with synchronous reset
package psc_pkg;
  localparam int PSC_PRIO_W       = 3;
  localparam int PSC_NPERIPH      = 8;
  localparam int PSC_DIV_W        = 2;
  localparam int PSC_CNT_W        = 3;
  // divisor encodings
  localparam logic [1:0] PSC_DIV1 = 2'h0;
  localparam logic [1:0] PSC_DIV2 = 2'h1;
  localparam logic [1:0] PSC_DIV4 = 2'h2;
  localparam logic [1:0] PSC_DIV8 = 2'h3;
  localparam logic [1:0] PSC_DIV_RESET = 2'h0;
  // field positions in oscillator_control_reg
  localparam int PSC_SLEEP_SEL_POS = 4;
  localparam int PSC_DIV_LSB       = 19;
  // start-up times in ns and derived cycle counts at 125 MHz
  localparam int PSC_CLK_NS        = 8;
  localparam int PSC_OSC_START_NS  = 1024;
  localparam int PSC_PLL_LOCK_NS   = 2048;
  localparam int PSC_OSC_START_CYC = (PSC_OSC_START_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
  localparam int PSC_PLL_LOCK_CYC  = (PSC_PLL_LOCK_NS + PSC_CLK_NS - 1) / PSC_CLK_NS;
  localparam int PSC_DLY_W         = 12;

  typedef enum logic [1:0] {
    PSC_RUN,
    PSC_IDLE,
    PSC_SLEEP
  } psc_mode_t;

  // last count value of the divider for a divisor code
  function automatic logic [2:0] psc_div_last(input logic [1:0] code);
    case (code)
      PSC_DIV1: psc_div_last = 3'h0;
      PSC_DIV2: psc_div_last = 3'h1;
      PSC_DIV4: psc_div_last = 3'h3;
      default:  psc_div_last = 3'h7;
    endcase
  endfunction : psc_div_last
endpackage : psc_pkg

// *** design/psc_clkdiv.sv ***
// psc_clkdiv: peripheral bus clock enable generator
// assumes the divisor code is stable or may change at any cycle
`timescale 1ns/1ps
module psc_clkdiv
  import psc_pkg::*;
(
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  reset,
  // control
  input  wire logic                  run,
  input  wire logic [psc_pkg::PSC_DIV_W-1:0] periph_clock_divisor,
  // output
  output logic                               pb_edge,
  output logic [psc_pkg::PSC_CNT_W-1:0]      count
);
  import psc_pkg::*;

  logic [PSC_CNT_W-1:0] next_count;
  logic                 next_pb_edge;
  logic [2:0]           last;

  always_comb begin
    last = psc_div_last(periph_clock_divisor);
    next_count   = count;
    next_pb_edge = 1'b0;
    if (run) begin
      // a divisor shrink past the count restarts at once, never waits a wrap
      if (count >= last) begin
        next_count   = '0;
        next_pb_edge = 1'b1;
      end else begin
        next_count = count + 3'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      count   <= '0;
      pb_edge <= 1'b0;
    end else begin
      count   <= next_count;
      pb_edge <= next_pb_edge;
    end
  end

  chk_edge_stopped: assert property (@(posedge clock) disable iff (reset) // RQ7
    !run |=> !pb_edge) else $error("peripheral edge while stopped");
  chk_div_one: assert property (@(posedge clock) disable iff (reset) // RQ10 RQ11
    (run && periph_clock_divisor == PSC_DIV1 && count == 3'h0) |=> pb_edge)
    else $error("1:1 divisor missed an edge");
endmodule : psc_clkdiv

// *** tb/psc_top_tb.sv ***
// psc_top_tb: self-checking bench for the power-save and peripheral clock block
// assumes psc_pkg is compiled first; start-up counts shortened to 4 cycles each
`timescale 1ns/1ps
module psc_top_tb;
  import psc_pkg::*;
  localparam int OSC_D = 4;
  localparam int PLL_D = 4;
  logic              clock, reset, wait_exec, sleep_select_bit, irq_valid, irq_runs_in_sleep;
  logic              wdt_timeout, periph_read_req, src_switch_req, src_was_disabled;
  logic              src_uses_xtal, src_uses_pll, core_halted, core_system_clock_run, sys_unit_clk_en;
  logic              peripheral_bus_clock, periph_read_done, src_ready;
  logic [1:0]        periph_clock_divisor;
  logic [2:0]        cpu_priority, irq_priority;
  logic [7:0]        stop_in_idle_bit, periph_clk_en;
  psc_mode_t         mode;
  int                n_errors, cmp_count;

  psc_top #(.NPERIPH(8), .OSC_DELAY(OSC_D), .PLL_DELAY(PLL_D)) psc_top_i (
    .clock(clock), .reset(reset), .wait_exec(wait_exec), .sleep_select_bit(sleep_select_bit),
    .periph_clock_divisor(periph_clock_divisor), .cpu_priority(cpu_priority),
    .irq_valid(irq_valid), .irq_runs_in_sleep(irq_runs_in_sleep), .irq_priority(irq_priority),
    .wdt_timeout(wdt_timeout), .stop_in_idle_bit(stop_in_idle_bit),
    .periph_read_req(periph_read_req), .src_switch_req(src_switch_req),
    .src_was_disabled(src_was_disabled), .src_uses_xtal(src_uses_xtal),
    .src_uses_pll(src_uses_pll), .core_halted(core_halted), .core_system_clock_run(core_system_clock_run),
    .sys_unit_clk_en(sys_unit_clk_en), .peripheral_bus_clock(peripheral_bus_clock),
    .periph_clk_en(periph_clk_en), .periph_read_done(periph_read_done),
    .src_ready(src_ready), .mode(mode));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic print_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // whole run is far below this; a hang ends here
  initial begin
    #400000;
    n_errors++;
    print_verdict();
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge clock);
    #1;
  endtask : step

  task automatic chk_state(input psc_mode_t m, input logic run, input logic [7:0] en);
    chk("mode", 8'(m), 8'(mode));
    chk("core_halted", 8'(m != PSC_RUN), 8'(core_halted));
    chk("core_system_clock_run", 8'(run), 8'(core_system_clock_run));
    chk("sys_unit_clk_en", 8'(run), 8'(sys_unit_clk_en));
    chk("periph_clk_en", en, periph_clk_en);
  endtask : chk_state

  task automatic do_wait(input logic sel);
    sleep_select_bit = sel;
    wait_exec = 1'b1;
    step();
    wait_exec = 1'b0;
  endtask : do_wait

  task automatic do_irq(input logic [2:0] p, input logic rs);
    irq_valid = 1'b1;
    irq_priority = p;
    irq_runs_in_sleep = rs;
    step();
    irq_valid = 1'b0;
  endtask : do_irq

  task automatic do_wdt();
    wdt_timeout = 1'b1;
    step();
    wdt_timeout = 1'b0;
  endtask : do_wdt

  task automatic test_idle();
    do_wait(1'b0);
    chk_state(PSC_IDLE, 1'b1, ~stop_in_idle_bit);
    do_irq(3'h3, 1'b1);
    chk_state(PSC_IDLE, 1'b1, ~stop_in_idle_bit);
    do_irq(3'h4, 1'b0);
    chk_state(PSC_RUN, 1'b1, 8'hff);
    do_wait(1'b0);
    do_wdt();
    chk_state(PSC_RUN, 1'b1, 8'hff);
    $display("test idle done");
  endtask : test_idle

  task automatic test_sleep();
    do_wait(1'b1);
    chk_state(PSC_SLEEP, 1'b0, 8'h00);
    do_wait(1'b0);
    chk_state(PSC_SLEEP, 1'b0, 8'h00);
    do_irq(3'h7, 1'b0);
    chk_state(PSC_SLEEP, 1'b0, 8'h00);
    do_irq(3'h2, 1'b1);
    chk_state(PSC_IDLE, 1'b1, ~stop_in_idle_bit);
    do_wdt();
    do_wait(1'b1);
    do_irq(3'h6, 1'b1);
    chk_state(PSC_RUN, 1'b1, 8'hff);
    do_wait(1'b1);
    do_wdt();
    chk_state(PSC_RUN, 1'b1, 8'hff);
    do_wait(1'b1);
    reset = 1'b1;
    step();
    reset = 1'b0;
    chk_state(PSC_RUN, 1'b1, 8'hff);
    $display("test sleep done");
  endtask : test_sleep

  task automatic test_div();
    int rises, lat, div;
    logic prev;
    for (int code = 0; code < 4; code++) begin
      div = 1 << code;
      periph_clock_divisor = 2'(code);
      repeat (10) step();
      if (code > 0) begin
        rises = 0;
        prev = peripheral_bus_clock;
        repeat (64) begin
          step();
          if (peripheral_bus_clock === 1'b1 && prev === 1'b0) rises++;
          prev = peripheral_bus_clock;
        end
        chk("pb_rises", 8'(64 / div), 8'(rises));
      end
      for (int k = 0; k < 3; k++) begin
        periph_read_req = 1'b1;
        step();
        periph_read_req = 1'b0;
        lat = 1;
        while (periph_read_done !== 1'b1 && lat < 20) begin
          step();
          lat++;
        end
        chk("read_in_window", 8'h01, 8'(lat <= div + 1));
        chk("pb_high_at_done", 8'h01, 8'(peripheral_bus_clock));
        chk("sys_unit_clk_en", 8'h01, 8'(sys_unit_clk_en));
        repeat (k) step();
      end
    end
    $display("test divisor done");
  endtask : test_div

  task automatic test_src(input logic dis, input logic x, input logic p, input int exp_low);
    int n;
    src_was_disabled = dis;
    src_uses_xtal = x;
    src_uses_pll = p;
    src_switch_req = 1'b1;
    step();
    src_switch_req = 1'b0;
    n = 0;
    while (src_ready !== 1'b1 && n < 50) begin
      step();
      n++;
    end
    chk("src_low_cycles", 8'(exp_low), 8'(n));
    $display("test source done");
  endtask : test_src

  initial begin
    n_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    {wait_exec, sleep_select_bit, irq_valid, irq_runs_in_sleep, wdt_timeout} = '0;
    {periph_read_req, src_switch_req, src_was_disabled, src_uses_xtal, src_uses_pll} = '0;
    periph_clock_divisor = PSC_DIV1;
    cpu_priority = 3'h3;
    irq_priority = 3'h0;
    stop_in_idle_bit = 8'ha5;
    repeat (8) step();
    reset = 1'b0;
    chk_state(PSC_RUN, 1'b1, 8'hff);
    chk("src_ready", 8'h01, 8'(src_ready));
    test_idle();
    test_sleep();
    test_div();
    test_src(1'b1, 1'b1, 1'b1, OSC_D + PLL_D);
    test_src(1'b1, 1'b1, 1'b0, OSC_D);
    test_src(1'b1, 1'b0, 1'b1, PLL_D);
    test_src(1'b0, 1'b1, 1'b1, 0);
    test_src(1'b1, 1'b0, 1'b0, 0);
    print_verdict();
  end
endmodule : psc_top_tb
